// ==== eep_pkg.sv ====
package eep_pkg;

  // ----------------------------------------------------------------
  // Array and page geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned PAGE_W    = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned SEL_W     = 3;

  // ----------------------------------------------------------------
  // Control byte layout and codes
  // ----------------------------------------------------------------
  localparam int unsigned CTL_CODE_HI = 7;
  localparam int unsigned CTL_CODE_LO = 4;
  localparam int unsigned CTL_SEL_HI  = 3;
  localparam int unsigned CTL_SEL_LO  = 1;
  localparam int unsigned CTL_DIR_BIT = 0;
  localparam logic [3:0]  CODE_MEM    = 4'ha;
  localparam logic [3:0]  CODE_PROT   = 4'h6;
  localparam logic        DIR_READ    = 1'h1;

  // ----------------------------------------------------------------
  // Bit counter, protection limit, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]        BIT_LAST  = 4'h7;
  localparam logic [3:0]        BIT_ACK   = 4'h8;
  localparam logic [3:0]        BIT_FIRST = 4'h1;
  localparam logic [ADDR_W-1:0] LOW_TOP   = 8'h7f;
  localparam logic [DATA_W-1:0] ERASED    = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ      = 100_000_000;
  localparam longint unsigned WR_CYCLE_MS = 10;
  // Longest time, so rounded down
  localparam int unsigned WR_CYCLE_CYC = int'((WR_CYCLE_MS * CLK_HZ) / 1000);

  // ----------------------------------------------------------------
  // Link engine states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_CTRL   = 6'b000010,
    ST_ADDR   = 6'b000100,
    ST_WDATA  = 6'b001000,
    ST_RDATA  = 6'b010000,
    ST_IGNORE = 6'b100000
  } eep_state_e;

  // Frame summary handed to the system clock at STOP
  typedef struct packed {
    logic                  wr;
    logic                  prot;
    logic [PAGE_W-1:0]     page;
    logic [PAGE_BYTES-1:0] valid;
  } eep_frame_s;

endpackage

// ==== eep_wr_timer.sv ====
`timescale 1ns/100ps
module eep_wr_timer #(
  parameter int unsigned CYCLES = eep_pkg::WR_CYCLE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o
);
  import eep_pkg::*;

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Self-timed cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= CNT_LOAD;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (cnt_r == '0) begin
        busy_o <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// ==== eep_slave.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - SDA falling while SCL high is START; every command opens with one.
// - SDA rising while SCL high is STOP; every operation closes with one.
// - Data changes only while SCL low; one bit per clock pulse.
// - Addressed receiver pulls SDA low through the ninth clock high phase.
// - Master NACK ends a read; slave then releases SDA high.
// - Upper control nibble 1010 means memory, 0110 means protect write.
// - Respond only when chip-select bits match the strap inputs.
// - No acknowledge for protect code combined with read direction.
// - Control byte bit zero: one reads, zero writes.
// - Byte write: control, word address into pointer, one data byte, each acked.
// - STOP after a write starts the timed cycle; no acks meanwhile.
// - Protected targets are acked but not stored; cycle time still runs.
// - Page write takes up to fifteen more bytes, committed after STOP.
// - Each data byte bumps only the low pointer nibble, wrapping in page; each read byte steps the whole pointer.
// - Overflowing a page keeps the newest sixteen bytes, oldest replaced.
// - Once protect is set, writes to 00h through 7Fh are blocked.
// - Protect is set by a 0110 write; address and data are ignored.
// - After protect is set, 0110 control bytes are not acknowledged.
// - Protect setting is permanent and survives power loss.
// - Protect pin high blocks every write and setting the protect bit.
// - Protect pin low leaves protection to the protect bit alone.
module eep_slave #(
  parameter int unsigned WR_CYCLES = eep_pkg::WR_CYCLE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  input  wire logic [eep_pkg::SEL_W-1:0] select_strap_inputs_i,
  input  wire logic                      wp_i,
  input  wire logic                      prot_nv_i,
  output logic                           prot_set_o,
  output logic                           busy_o
);
  import eep_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                  start_tgl_r;
  logic                  stop_tgl_r;
  logic                  start_seen_r;
  eep_state_e            state_r;
  logic [3:0]            bitcnt_r;
  logic [DATA_W-1:0]     shreg_r;
  logic                  ack_r;
  logic                  cmd_prot_r;
  logic [ADDR_W-1:0]     ptr_r;
  logic [DATA_W-1:0]     page_buf_r [PAGE_BYTES];
  eep_frame_s            frame_r;
  logic [SEL_W-1:0]      strap_m_r;
  logic [SEL_W-1:0]      strap_s_r;
  logic [1:0]            busy_l_r;
  logic [1:0]            prot_l_r;
  logic [1:0]            stop_sync_r;
  logic                  stop_seen_r;
  logic [1:0]            wp_sync_r;
  logic [1:0]            nv_sync_r;
  logic                  prot_set_r;
  logic [DATA_W-1:0]     mem_r [MEM_BYTES];
  logic                  timer_busy;

  logic                  start_new;
  logic [DATA_W-1:0]     rx_byte;
  logic                  byte_end;
  logic                  ack_slot;
  logic                  ctl_sel;
  logic                  ctl_rd;
  logic                  mem_ok;
  logic                  prot_ok;
  logic                  busy_s;
  logic                  prot_s;
  logic [DATA_W-1:0]     rd_byte;
  logic                  stop_evt;
  logic                  commit;
  logic                  wp_s;

  // ----------------------------------------------------------------
  // Bus conditions on the data line edges
  // ----------------------------------------------------------------
  // Toggles rather than pulses: no clock runs at the moment a
  // condition happens, so each consumer compares against its copy.
  always_ff @(negedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_tgl_r <= 1'b0;
    end else if (scl_i) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  always_ff @(posedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // Link side: receive decode
  // ----------------------------------------------------------------
  // START toggle settles before the first rising clock of the frame
  assign start_new = start_tgl_r ^ start_seen_r;
  assign rx_byte   = {shreg_r[DATA_W-2:0], sda_i};
  assign byte_end  = !start_new && (bitcnt_r == BIT_LAST);
  assign ack_slot  = !start_new && (bitcnt_r == BIT_ACK);
  assign busy_s    = busy_l_r[1];
  assign prot_s    = prot_l_r[1];
  assign ctl_sel   = (rx_byte[CTL_SEL_HI:CTL_SEL_LO] == strap_s_r);
  assign ctl_rd    = (rx_byte[CTL_DIR_BIT] == DIR_READ);
  // Busy frames stay silent, which is what polling relies on
  assign mem_ok    = (rx_byte[CTL_CODE_HI:CTL_CODE_LO] == CODE_MEM)
                   && ctl_sel && !busy_s;
  assign prot_ok   = (rx_byte[CTL_CODE_HI:CTL_CODE_LO] == CODE_PROT)
                   && ctl_sel && !ctl_rd && !prot_s && !busy_s;
  assign rd_byte   = mem_r[ptr_r];

  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_seen_r <= 1'b0;
    end else begin
      start_seen_r <= start_tgl_r;
    end
  end

  // Static straps and system-side levels, two stages each
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_m_r <= '0;
      strap_s_r <= '0;
      busy_l_r  <= '0;
      prot_l_r  <= '0;
    end else begin
      strap_m_r <= select_strap_inputs_i;
      strap_s_r <= strap_m_r;
      busy_l_r  <= {busy_l_r[0], timer_busy};
      prot_l_r  <= {prot_l_r[0], prot_set_r};
    end
  end

  // ----------------------------------------------------------------
  // Link side: bit engine
  // ----------------------------------------------------------------
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_IDLE;
      bitcnt_r   <= '0;
      shreg_r    <= '0;
      ack_r      <= 1'b0;
      cmd_prot_r <= 1'b0;
    end else if (start_new) begin
      state_r    <= ST_CTRL;
      bitcnt_r   <= BIT_FIRST;
      shreg_r    <= {{(DATA_W-1){1'b0}}, sda_i};
      ack_r      <= 1'b0;
      cmd_prot_r <= 1'b0;
    end else if (ack_slot) begin
      bitcnt_r <= '0;
      ack_r    <= 1'b0;
      if (state_r == ST_RDATA && !ack_r && sda_i) begin
        state_r <= ST_IGNORE;
      end
    end else begin
      bitcnt_r <= bitcnt_r + 1'b1;
      shreg_r  <= rx_byte;
      if (byte_end) begin
        unique case (state_r)
          ST_CTRL: begin
            ack_r      <= mem_ok || prot_ok;
            cmd_prot_r <= prot_ok;
            if (mem_ok) begin
              state_r <= ctl_rd ? ST_RDATA : ST_ADDR;
            end else if (prot_ok) begin
              state_r <= ST_ADDR;
            end else begin
              state_r <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            ack_r   <= 1'b1;
            state_r <= ST_WDATA;
          end
          ST_WDATA: begin
            ack_r <= 1'b1;
          end
          ST_IDLE, ST_RDATA, ST_IGNORE: begin
            ack_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side: address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_r <= '0;
    end else if (byte_end && state_r == ST_ADDR && !cmd_prot_r) begin
      ptr_r <= rx_byte;
    end else if (byte_end && state_r == ST_WDATA && !cmd_prot_r) begin
      ptr_r[PAGE_W-1:0] <= ptr_r[PAGE_W-1:0] + 1'b1;
    end else if (ack_slot && state_r == ST_RDATA && !ack_r) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Link side: page buffer and frame summary
  // ----------------------------------------------------------------
  // Slots are indexed by the wrapping nibble, so a seventeenth byte
  // lands on the oldest slot and the newest sixteen survive.
  always_ff @(posedge scl_i) begin
    if (byte_end && state_r == ST_WDATA && !cmd_prot_r) begin
      page_buf_r[ptr_r[PAGE_W-1:0]] <= rx_byte;
    end
  end

  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_r <= '0;
    end else if (start_new) begin
      frame_r <= '0;
    end else if (byte_end && state_r == ST_WDATA) begin
      if (cmd_prot_r) begin
        frame_r.prot <= 1'b1;
      end else begin
        frame_r.wr                      <= 1'b1;
        frame_r.page                    <= ptr_r[ADDR_W-1:PAGE_W];
        frame_r.valid[ptr_r[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side: data line drive on falling clock
  // ----------------------------------------------------------------
  always_ff @(negedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_oe_o <= 1'b0;
    end else if (bitcnt_r == BIT_ACK) begin
      sda_oe_o <= ack_r;
    end else if (state_r == ST_RDATA) begin
      sda_oe_o <= ~rd_byte[~bitcnt_r[2:0]];
    end else begin
      sda_oe_o <= 1'b0;
    end
  end

  // Open drain: the level itself never leaves low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System side: synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_sync_r <= '0;
      stop_seen_r <= 1'b0;
    end else begin
      stop_sync_r <= {stop_sync_r[0], stop_tgl_r};
      stop_seen_r <= stop_sync_r[1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_sync_r <= '0;
      nv_sync_r <= '0;
    end else begin
      wp_sync_r <= {wp_sync_r[0], wp_i};
      nv_sync_r <= {nv_sync_r[0], prot_nv_i};
    end
  end

  assign stop_evt = stop_sync_r[1] ^ stop_seen_r;
  assign wp_s     = wp_sync_r[1];
  // Frame summary and page buffer are quiet here: the bus is idle
  // after STOP and every later frame is refused until the cycle ends.
  assign commit   = stop_evt && !timer_busy && (frame_r.wr || frame_r.prot);

  // ----------------------------------------------------------------
  // System side: protect bit
  // ----------------------------------------------------------------
  // Only ever ORs in; the nonvolatile cell is mirrored by prot_nv_i.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prot_set_r <= 1'b0;
    end else if (nv_sync_r[1]) begin
      prot_set_r <= 1'b1;
    end else if (commit && frame_r.prot && !wp_s) begin
      prot_set_r <= 1'b1;
    end
  end

  assign prot_set_o = prot_set_r;

  // ----------------------------------------------------------------
  // System side: array commit
  // ----------------------------------------------------------------
  // Whole page lands in one cycle; the timed busy window follows.
  for (genvar g = 0; g < MEM_BYTES; g++) begin : g_mem
    localparam logic [ADDR_W-1:0] G_ADDR = ADDR_W'(g);
    logic blocked;
    assign blocked = wp_s || (prot_set_r && G_ADDR <= LOW_TOP);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_r[g] <= ERASED;
      end else if (commit && frame_r.wr && !blocked
                   && frame_r.page == G_ADDR[ADDR_W-1:PAGE_W]
                   && frame_r.valid[G_ADDR[PAGE_W-1:0]]) begin
        mem_r[g] <= page_buf_r[G_ADDR[PAGE_W-1:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // System side: write cycle timer
  // ----------------------------------------------------------------
  // Started even when nothing is stored, so polling behaves the same
  eep_wr_timer #(
    .CYCLES (WR_CYCLES)
  ) u_wr_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (commit),
    .busy_o  (timer_busy)
  );

  assign busy_o = timer_busy;

endmodule

// ==== eep_slave_monitor.sv ====
`timescale 1ns/100ps
module eep_slave_monitor #(
  parameter int unsigned WR_CYCLES = eep_pkg::WR_CYCLE_CYC
) (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      scl_i,
  input wire logic                      sda_i,
  input wire logic                      sda_o,
  input wire logic                      sda_oe_o,
  input wire logic [eep_pkg::SEL_W-1:0] select_strap_inputs_i,
  input wire logic                      wp_i,
  input wire logic                      prot_nv_i,
  input wire logic                      prot_set_o,
  input wire logic                      busy_o
);
  // ----------------
  // Busy length count
  // ----------------
  int unsigned busy_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cnt_r <= 0;
    else if (busy_o) busy_cnt_r <= busy_cnt_r + 1;
    else busy_cnt_r <= 0;
  end
  a_sda_only_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sda_oe_o |-> !sda_o) else $error("slave drives a high level");
  a_oe_stable_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("sda moved with scl high");
  a_idle_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    scl_i [*4] |-> !sda_oe_o) else $error("sda held while clock idles");
  a_busy_nack: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    busy_o && $past(busy_o) && $past(busy_o, 2) |-> !sda_oe_o)
    else $error("acknowledge during write cycle");
  a_busy_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> busy_cnt_r == WR_CYCLES) else $error("write cycle length wrong");
  a_busy_after_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(busy_o) |-> scl_i && sda_i) else $error("write cycle began inside a frame");
  a_prot_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prot_set_o |=> prot_set_o) else $error("protect bit cleared");
  a_prot_nv_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prot_nv_i |-> ##[0:4] prot_set_o) else $error("stored protect not restored");
  a_prot_wp_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(prot_set_o) |-> !wp_i || prot_nv_i) else $error("protect set while pin high");
  c_busy: cover property (@(posedge clk_i) $rose(busy_o));
  c_prot: cover property (@(posedge clk_i) $rose(prot_set_o));
  c_ack: cover property (@(posedge scl_i) sda_oe_o);
endmodule

bind eep_slave eep_slave_monitor #(.WR_CYCLES(WR_CYCLES)) eep_slave_monitor_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .select_strap_inputs_i(select_strap_inputs_i), .wp_i(wp_i),
  .prot_nv_i(prot_nv_i), .prot_set_o(prot_set_o), .busy_o(busy_o));

// ==== eep_bus_master.sv ====
`timescale 1ns/100ps
// ----------------
// Two-wire master
// ----------------
// Clock stands high between frames; released data goes to the pull-up
module eep_bus_master (
  output logic      scl_o,
  output logic      pull_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic start();
    #5 pull_o = 1'b0;
    #10 scl_o = 1'b1;
    #15 pull_o = 1'b1;
    #15 scl_o = 1'b0;
  endtask
  // Long idle keeps the bus free time
  task automatic stop();
    #5 pull_o = 1'b1;
    #10 scl_o = 1'b1;
    #15 pull_o = 1'b0;
    #60;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #5 pull_o = !b;
    #10 scl_o = 1'b1;
    #14 r = sda_i;
    #1 scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ==== eep_slave_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module eep_slave_tb_top;
  import eep_pkg::*;
  localparam logic [7:0] CW = 8'haa;
  localparam logic [7:0] CR = 8'hab;
  localparam logic [7:0] CP = 8'h6a;
  logic       clk, rst_n, wp, prot_nv, scl, pull, sda_o, sda_oe, prot_set, busy;
  logic       sda;
  logic [2:0] strap;
  int         num_errors = 0;
  int         check_count = 0;
  // Rows: control byte, expected acknowledge
  logic [8:0] rows [7] = '{9'h155, 9'h157, 9'h144, 9'h15c, 9'h0d6, 9'h0b4, 9'h0d5};
  assign sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  eep_slave #(.WR_CYCLES(50)) eep_slave_i (
    .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .select_strap_inputs_i(strap), .wp_i(wp), .prot_nv_i(prot_nv),
    .prot_set_o(prot_set), .busy_o(busy));
  eep_bus_master eep_bus_master_i (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 300 && busy !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== v) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic ctl(input logic [7:0] c, input logic e);
    logic       ack;
    logic [7:0] d;
    eep_bus_master_i.start();
    eep_bus_master_i.wbyte(c, ack);
    `CHK(ack, e)
    if (ack && c[0]) begin
      eep_bus_master_i.rbyte(1'b1, d);
      `CHK(d, ERASED)
    end
    eep_bus_master_i.stop();
  endtask
  // Write frame, then poll busy and idle
  task automatic wr(input logic [7:0] c, input logic [7:0] a, input int n, input logic [7:0] b);
    logic ack;
    eep_bus_master_i.start();
    eep_bus_master_i.wbyte(c, ack);
    `CHK(ack, 1'b1)
    eep_bus_master_i.wbyte(a, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      eep_bus_master_i.wbyte(b + 8'(i), ack);
      `CHK(ack, 1'b1)
    end
    eep_bus_master_i.stop();
    wait_busy(1'b1);
    ctl(CW, 1'b0);
    wait_busy(1'b0);
    ctl(CW, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1,
                    input logic two);
    logic       ack;
    logic [7:0] d;
    eep_bus_master_i.start();
    eep_bus_master_i.wbyte(CW, ack);
    eep_bus_master_i.wbyte(a, ack);
    eep_bus_master_i.start();
    eep_bus_master_i.wbyte(CR, ack);
    eep_bus_master_i.rbyte(!two, d);
    `CHK(d, e0)
    if (two) begin
      eep_bus_master_i.rbyte(1'b1, d);
      `CHK(d, e1)
    end
    eep_bus_master_i.stop();
  endtask
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    prot_nv = 1'b0;
    strap = 3'h5;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    foreach (rows[k]) ctl(rows[k][8:1], rows[k][0]);
    wr(CW, 8'h85, 1, 8'h3c);
    rd(8'h85, 8'h3c, 8'h00, 1'b0);
    wr(CW, 8'h20, 18, 8'h40);
    rd(8'h21, 8'h51, 8'h42, 1'b1);
    rd(8'h2f, 8'h4f, ERASED, 1'b1);
    @(posedge clk);
    #1 wp = 1'b1;
    wr(CW, 8'h90, 1, 8'h11);
    rd(8'h90, ERASED, 8'h00, 1'b0);
    wr(CP, 8'h00, 1, 8'h00);
    `CHK(prot_set, 1'b0)
    @(posedge clk);
    #1 wp = 1'b0;
    wr(CP, 8'h00, 1, 8'h00);
    `CHK(prot_set, 1'b1)
    ctl(CP, 1'b0);
    wr(CW, 8'h10, 1, 8'h55);
    rd(8'h10, ERASED, 8'h00, 1'b0);
    wr(CW, 8'h86, 1, 8'h77);
    rd(8'h86, 8'h77, 8'h00, 1'b0);
    @(posedge clk);
    #1 rst_n = 1'b0;
    #2 `CHK({prot_set, busy, sda_oe}, 3'h0)
    prot_nv = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 `CHK(prot_set, 1'b1)
    ctl(CP, 1'b0);
    rd(8'h85, ERASED, 8'h00, 1'b0);
    // Straps moved between frames: only the new select answers
    @(posedge clk);
    #1 strap = 3'h2;
    ctl(8'ha4, 1'b1);
    ctl(CW, 1'b0);
    conclude();
  end
endmodule
